// ---- hdl/cerb_ram.sv ----
// configurable embedded ram block with apb configuration and two user ports
`timescale 1ns/1ps
`default_nettype none
module cerb_ram (
    // clock and reset
    input  wire  logic                             pclk,
    input  wire  logic                             presetn,
    // apb slave
    input  wire  logic                             psel,
    input  wire  logic                             penable,
    input  wire  logic                             pwrite,
    input  wire  logic [cerb_pkg::APB_AW-1:0]      paddr,
    input  wire  logic [31:0]                      pwdata,
    output logic       [31:0]                      prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // port a, narrow
    input  wire  logic [cerb_pkg::ADDR_A_W-1:0]    a_addr,
    input  wire  logic [cerb_pkg::NARROW_W-1:0]    a_wdata,
    input  wire  logic                             a_we,
    input  wire  logic                             a_re,
    output logic       [cerb_pkg::NARROW_W-1:0]    a_q,
    // port b, wide with parity and byte enables
    input  wire  logic [cerb_pkg::ADDR_B_W-1:0]    b_addr,
    input  wire  logic [cerb_pkg::DATA_W-1:0]      b_wdata,
    input  wire  logic [cerb_pkg::NBYTES-1:0]      b_wpar,
    input  wire  logic [cerb_pkg::NBYTES-1:0]      b_be,
    input  wire  logic                             b_we,
    input  wire  logic                             b_re,
    output logic       [cerb_pkg::DATA_W-1:0]      b_q,
    output logic       [cerb_pkg::NBYTES-1:0]      b_qpar
);
    import cerb_pkg::*;

    // decode a mode field; the unused code falls back to simple dual-port
    function automatic cerb_mode_t dec_mode(input logic [1:0] f);
        cerb_mode_t m;
        m = MODE_SIMPLE;
        if (f == 2'h0) begin
            m = MODE_SINGLE;
        end else if (f == 2'h2) begin
            m = MODE_TRUE;
        end
        return m;
    endfunction : dec_mode

    // decode a size field; the unused code falls back to the large block
    function automatic cerb_size_t dec_size(input logic [1:0] f);
        cerb_size_t s;
        s = SIZE_LARGE;
        if (f == 2'h0) begin
            s = SIZE_SMALL;
        end else if (f == 2'h1) begin
            s = SIZE_MEDIUM;
        end
        return s;
    endfunction : dec_size

    logic [CTRL_W:0]        ctrl_reg;
    logic                   coll_reg;
    logic [WORD_W-1:0]      mem [DEPTH];

    // input registers of both ports
    logic [ADDR_A_W-1:0]    a_addr_reg;
    logic [NARROW_W-1:0]    a_wdata_reg;
    logic                   a_we_reg;
    logic                   a_re_reg;
    logic [ADDR_B_W-1:0]    b_addr_reg;
    logic [DATA_W-1:0]      b_wdata_reg;
    logic [NBYTES-1:0]      b_wpar_reg;
    logic [NBYTES-1:0]      b_be_reg;
    logic                   b_we_reg;
    logic                   b_re_reg;
    // falling-edge read registers for flow-through
    logic [ADDR_B_W-1:0]    b_addr_neg_reg;
    logic                   b_re_neg_reg;
    // output registers
    logic [NARROW_W-1:0]    a_q_reg;
    logic [DATA_W-1:0]      b_q_reg;
    logic [NBYTES-1:0]      b_qpar_reg;

    cerb_mode_t             req_mode;
    cerb_mode_t             mode;
    cerb_size_t             size;
    logic                   lock;
    logic                   split;
    logic                   flow;
    logic                   oreg_a;
    logic                   oreg_b;
    logic                   old_data;
    logic                   true_ok;
    logic                   flow_ok;
    logic                   a_wr;
    logic                   b_wr;
    logic                   a_rd;
    logic                   b_rd;
    logic [ADDR_B_W-1:0]    a_word;
    logic [ADDR_B_W-1:0]    b_word;
    logic [SUB_W-1:0]       a_sub;
    logic [ADDR_B_W-1:0]    b_raddr;
    logic [NBYTES-1:0]      be_eff;
    logic [NARROW_W-1:0]    a_q_next;
    logic [DATA_W-1:0]      b_q_next;
    logic [NBYTES-1:0]      b_qpar_next;
    logic                   apb_wr;
    logic                   hit_ctrl;
    logic                   hit_stat;

    // configuration decode
    assign req_mode = dec_mode(ctrl_reg[CTRL_MODE_LSB +: 2]);
    assign size     = dec_size(ctrl_reg[CTRL_SIZE_LSB +: 2]);
    assign true_ok  = (size != SIZE_SMALL);
    assign mode     = (req_mode == MODE_TRUE && !true_ok) ? MODE_SIMPLE : req_mode;
    assign flow_ok  = (mode == MODE_SIMPLE) && (size != SIZE_LARGE);
    assign flow     = ctrl_reg[CTRL_FLOW] && flow_ok;
    // splitting only makes sense for two single ports in a medium block
    assign split    = ctrl_reg[CTRL_SPLIT] && mode == MODE_SINGLE
                      && size == SIZE_MEDIUM;
    assign lock     = ctrl_reg[CTRL_LOCK];
    assign oreg_a   = ctrl_reg[CTRL_OREG_A];
    assign oreg_b   = ctrl_reg[CTRL_OREG_B];
    assign old_data = ctrl_reg[CTRL_OLD_DATA];

    // apb slave: zero wait states, error on unmapped offsets
    assign hit_ctrl = (paddr == CTRL_OFF);
    assign hit_stat = (paddr == STAT_OFF);
    assign apb_wr   = psel && penable && pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !(hit_ctrl || hit_stat);

    // read mux for the two registers, unmapped reads as zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_ctrl) begin
            prdata[CTRL_W:0] = ctrl_reg;
        end else if (hit_stat) begin
            prdata[STAT_COLL]    = coll_reg;
            prdata[STAT_LOCK]    = lock;
            prdata[STAT_TRUE_OK] = true_ok;
            prdata[STAT_FLOW_OK] = flow_ok;
        end
    end

    // control register; the lock bit can only be set, reset clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= {1'b0, CTRL_RST};
        end else if (apb_wr && hit_ctrl) begin
            ctrl_reg           <= pwdata[CTRL_W:0];
            ctrl_reg[CTRL_LOCK] <= ctrl_reg[CTRL_LOCK] | pwdata[CTRL_LOCK];
        end
    end

    // sticky collision flag, write one to clear; a new collision wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coll_reg <= 1'b0;
        end else if (a_wr && b_wr && a_word == b_word) begin
            coll_reg <= 1'b1;
        end else if (apb_wr && hit_stat && pwdata[STAT_COLL]) begin
            coll_reg <= 1'b0;
        end
    end

    // input registers; one clock serves the write side of every size
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_addr_reg  <= '0;
            a_wdata_reg <= '0;
            a_we_reg    <= 1'b0;
            a_re_reg    <= 1'b0;
            b_addr_reg  <= '0;
            b_wdata_reg <= '0;
            b_wpar_reg  <= '0;
            b_be_reg    <= '0;
            b_we_reg    <= 1'b0;
            b_re_reg    <= 1'b0;
        end else begin
            a_addr_reg  <= a_addr;
            a_wdata_reg <= a_wdata;
            a_we_reg    <= a_we;
            a_re_reg    <= a_re;
            b_addr_reg  <= b_addr;
            b_wdata_reg <= b_wdata;
            b_wpar_reg  <= b_wpar;
            b_be_reg    <= b_be;
            b_we_reg    <= b_we;
            b_re_reg    <= b_re;
        end
    end

    // read address taken half a cycle early so data flows out this cycle
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_addr_neg_reg <= '0;
            b_re_neg_reg   <= 1'b0;
        end else begin
            b_addr_neg_reg <= b_addr;
            b_re_neg_reg   <= b_re;
        end
    end

    // address mapping; split mode pins each port to its own half
    assign a_sub   = a_addr_reg[SUB_W-1:0];
    assign a_word  = split ? {1'b0, a_addr_reg[ADDR_A_W-2:SUB_W]}
                           : a_addr_reg[ADDR_A_W-1:SUB_W];
    assign b_raddr = flow ? b_addr_neg_reg : b_addr_reg;
    assign b_word  = split ? {1'b1, b_raddr[ADDR_B_W-2:0]} : b_raddr;

    // port roles per mode; simple dual-port writes on a, reads on b
    assign a_wr = a_we_reg && !lock;
    assign b_wr = b_we_reg && !lock && (mode == MODE_TRUE || split);
    // in single-port, port a never reads while writing; the write shows instead
    assign a_rd = a_re_reg && mode != MODE_SIMPLE
                  && !(mode == MODE_SINGLE && a_we_reg);
    assign b_rd = (flow ? b_re_neg_reg : b_re_reg)
                  && (mode != MODE_SINGLE || split);
    // small block has no byte enables
    assign be_eff = (size == SIZE_SMALL) ? '1 : b_be_reg;

    // array write: the registered enable strobes exactly one edge;
    // b is applied last, so it wins a same-word collision
    always_ff @(posedge pclk) begin
        if (a_wr) begin
            mem[a_word][a_sub*NARROW_W +: NARROW_W] <= a_wdata_reg;
        end
        if (b_wr) begin
            for (int i = 0; i < NBYTES; i++) begin
                if (be_eff[i]) begin
                    mem[b_word][i*8 +: 8]     <= b_wdata_reg[i*8 +: 8];
                    mem[b_word][DATA_W + i]   <= b_wpar_reg[i];
                end
            end
        end
    end

    // port a read path; in single-port a write is passed straight through
    always_comb begin
        a_q_next = mem[a_word][a_sub*NARROW_W +: NARROW_W];
        if (mode == MODE_SINGLE && a_wr) begin
            a_q_next = a_wdata_reg;
        end
    end

    // port b read path with mixed-port read-during-write handling
    always_comb begin
        b_q_next    = mem[b_word][DATA_W-1:0];
        b_qpar_next = mem[b_word][WORD_W-1:DATA_W];
        if (mode != MODE_SINGLE && a_wr && a_word == b_word && !old_data) begin
            b_q_next    = UNDEF_PAT;
            b_qpar_next = '0;
        end
    end

    // output registers load only on a read, or on a port a single-port write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q_reg <= '0;
        end else if (a_rd || (mode == MODE_SINGLE && a_wr)) begin
            a_q_reg <= a_q_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_q_reg    <= '0;
            b_qpar_reg <= '0;
        end else if (b_rd) begin
            b_q_reg    <= b_q_next;
            b_qpar_reg <= b_qpar_next;
        end
    end

    // output select; flow-through always bypasses the output register
    assign a_q    = oreg_a ? a_q_reg : a_q_next;
    assign b_q    = (oreg_b && !flow) ? b_q_reg : b_q_next;
    assign b_qpar = (oreg_b && !flow) ? b_qpar_reg : b_qpar_next;
endmodule : cerb_ram
`default_nettype wire

// ---- hdl/cerb_pkg.sv ----
// constants, field layout and mode types of the configurable embedded ram block
// What this block does
// - true dual-port: any two reads or writes
// - true dual-port only on medium and large
// - simple dual-port read-during-write: old or undefined
// - single-port: port a write appears on a_q; split port b reads old data during a write
// - ports may have different data widths
// - every port input captured in input register
// - write strobe generated internally from clock
// - read output register can be bypassed
// - flow-through reads: falling-edge read address, bypass
// - medium block holds two half-size single ports
// - large block: no preload, write once then lock
// - each stored byte carries a parity bit
// - medium and large: per-byte write enables
// - small block: write registers share one clock
package cerb_pkg;
    // storage geometry: wide port word, narrow port slice
    localparam int DATA_W    = 16;
    localparam int NBYTES    = DATA_W / 8;
    localparam int WORD_W    = DATA_W + NBYTES;
    localparam int DEPTH     = 32;
    localparam int ADDR_B_W  = 5;
    localparam int NARROW_W  = 1;
    localparam int SUB_W     = 4;
    localparam int ADDR_A_W  = ADDR_B_W + SUB_W;

    // apb map
    localparam int          APB_AW      = 8;
    localparam logic [7:0]  CTRL_OFF    = 8'h00;
    localparam logic [7:0]  STAT_OFF    = 8'h04;

    // control register fields
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_SIZE_LSB = 2;
    localparam int          CTRL_OREG_A   = 4;
    localparam int          CTRL_OREG_B   = 5;
    localparam int          CTRL_OLD_DATA = 6;
    localparam int          CTRL_FLOW     = 7;
    localparam int          CTRL_SPLIT    = 8;
    localparam int          CTRL_LOCK     = 9;
    localparam int          CTRL_W        = 9;
    localparam logic [8:0]  CTRL_RST      = 9'h075;

    // status register fields
    localparam int          STAT_COLL     = 0;
    localparam int          STAT_LOCK     = 1;
    localparam int          STAT_TRUE_OK  = 2;
    localparam int          STAT_FLOW_OK  = 3;

    // pattern returned for an undefined mixed-port read
    localparam logic [15:0] UNDEF_PAT     = 16'hDEAD;

    typedef enum logic [1:0] {MODE_SINGLE, MODE_SIMPLE, MODE_TRUE} cerb_mode_t;
    typedef enum logic [1:0] {SIZE_SMALL, SIZE_MEDIUM, SIZE_LARGE} cerb_size_t;
endpackage : cerb_pkg

// ---- verification/cerb_ram_props.sv ----
// port-level assertion checker for the embedded ram block
`timescale 1ns/1ps
`default_nettype none
module cerb_ram_props (
    // clock, reset and apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // user ports
    input wire logic [8:0]  a_addr,
    input wire logic        a_we,
    input wire logic        a_re,
    input wire logic [0:0]  a_q,
    input wire logic [4:0]  b_addr,
    input wire logic        b_we,
    input wire logic        b_re,
    input wire logic [15:0] b_q
);
    import cerb_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [9:0] ctrl_reg;
    logic [3:0] a_bit;
    logic       acc, simple_m, true_m;
    // shadow of the control word; lock can only be set until reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= {1'b0, CTRL_RST};
        end else if (psel && penable && pwrite && paddr == CTRL_OFF) begin
            ctrl_reg <= pwdata[9:0] | {ctrl_reg[9], 9'h000};
        end
    end
    // decoded configuration, modes 1 and 3 both run simple dual-port
    assign acc      = psel && penable;
    assign simple_m = ctrl_reg[0];
    assign true_m   = ctrl_reg[1:0] == 2'b10;
    assign a_bit    = a_addr[3:0];
    sequence rd_both;
        a_re && b_re && !a_we && !b_we && a_addr[8:4] == b_addr;
    endsequence
    sequence rw_clash;
        a_we && b_re && a_addr[8:4] == b_addr;
    endsequence
    AST_PREADY: assert property (psel |-> pready)
        else $error("pready low during a transfer");
    AST_SLVERR: assert property (acc |-> pslverr == (paddr != CTRL_OFF && paddr != STAT_OFF))
        else $error("slave error does not match the address map");
    AST_CTRL_READ: assert property (acc && !pwrite && paddr == CTRL_OFF |-> prdata[9:0] == ctrl_reg)
        else $error("control readback differs from written value");
    AST_LOCK_STAT: assert property (acc && !pwrite && paddr == STAT_OFF |-> prdata[STAT_LOCK] == ctrl_reg[9])
        else $error("lock status wrong");
    AST_TRUE_OK: assert property (acc && !pwrite && paddr == STAT_OFF && true_m
        |-> prdata[STAT_TRUE_OK] == (ctrl_reg[3:2] != 2'b00)) else $error("true dual status wrong");
    AST_FLOW_OK: assert property (acc && !pwrite && paddr == STAT_OFF && simple_m && ctrl_reg[7]
        |-> prdata[STAT_FLOW_OK] == !ctrl_reg[3]) else $error("flow-through status wrong");
    AST_MIXED_WIDTH: assert property ((true_m && ctrl_reg[5:4] == 2'b00 && ctrl_reg[3:2] != 2'b00)
        ##0 rd_both |=> a_q[0] == b_q[$past(a_bit)]) else $error("narrow bit differs from wide word");
    AST_UNDEF_READ: assert property ((simple_m && ctrl_reg[7:5] == 3'b000 && !ctrl_reg[9])
        ##0 rw_clash |=> b_q == UNDEF_PAT) else $error("clashing read not undefined pattern");
    // a control write at the same edge may switch the output mux, so it is left out
    AST_B_HOLD: assert property (true_m && ctrl_reg[5] && !$past(b_re)
        && !(acc && pwrite && paddr == CTRL_OFF) |=> $stable(b_q))
        else $error("registered read data moved without a read");
endmodule : cerb_ram_props

bind cerb_ram cerb_ram_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .a_addr(a_addr), .a_we(a_we), .a_re(a_re), .a_q(a_q),
    .b_addr(b_addr), .b_we(b_we), .b_re(b_re), .b_q(b_q)
);
`default_nettype wire

// ---- verification/cerb_user_model.sv ----
// model of the fabric logic that drives both user ports
`timescale 1ns/1ps
`default_nettype none
module cerb_user_model (
    // clock
    input  wire logic        pclk,
    // port a
    output var  logic [8:0]  a_addr,
    output var  logic [0:0]  a_wdata,
    output var  logic        a_we,
    output var  logic        a_re,
    // port b
    output var  logic [4:0]  b_addr,
    output var  logic [15:0] b_wdata,
    output var  logic [1:0]  b_wpar,
    output var  logic [1:0]  b_be,
    output var  logic        b_we,
    output var  logic        b_re
);
    // idle lines from time zero
    initial begin
        {a_addr, a_wdata, a_we, a_re, b_addr, b_wdata, b_wpar, b_be, b_we, b_re} = '0;
    end
    // one operation per port in one cycle, then release
    task automatic op(input logic aw, input logic ar, input logic [8:0] aa, input logic ad,
                      input logic bw, input logic br, input logic [4:0] ba,
                      input logic [15:0] bd, input logic [1:0] be);
        @(posedge pclk);
        a_we    <= aw && !(bw && aa[8:4] == ba);
        a_re    <= ar;
        a_addr  <= aa;
        a_wdata <= ad;
        b_we    <= bw;
        b_re    <= br;
        b_addr  <= ba;
        b_wdata <= bd;
        b_be    <= be;
        b_wpar  <= {^bd[15:8], ^bd[7:0]};
        @(posedge pclk);
        {a_we, a_re, b_we, b_re} <= 4'h0;
        // released data lines flip so stale values never pass for live ones
        a_wdata <= ~ad;
        b_wdata <= ~bd;
    endtask : op
endmodule : cerb_user_model
`default_nettype wire

// ---- verification/configurable_embedded_ram_bench.sv ----
// self-checking bench for the embedded ram block
`timescale 1ns/1ps
`default_nettype none
module configurable_embedded_ram_bench;
    import cerb_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        a_we, a_re, b_we, b_re;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0]  a_addr;
    logic [0:0]  a_wdata, a_q;
    logic [4:0]  b_addr;
    logic [15:0] b_wdata, b_q;
    logic [1:0]  b_wpar, b_be, b_qpar;
    int          mismatches, num_checks;
    cerb_ram dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .a_addr(a_addr), .a_wdata(a_wdata), .a_we(a_we), .a_re(a_re), .a_q(a_q),
        .b_addr(b_addr), .b_wdata(b_wdata), .b_wpar(b_wpar), .b_be(b_be), .b_we(b_we),
        .b_re(b_re), .b_q(b_q), .b_qpar(b_qpar));
    cerb_user_model u_usr (
        .pclk(pclk), .a_addr(a_addr), .a_wdata(a_wdata), .a_we(a_we), .a_re(a_re),
        .b_addr(b_addr), .b_wdata(b_wdata), .b_wpar(b_wpar), .b_be(b_be), .b_we(b_we),
        .b_re(b_re));
    // 50 MHz clock
    always #10 pclk = ~pclk;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one apb transfer; waits on pready under a bound
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            report_and_stop();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic t_regs;
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(rd, 32'h0000_0075);
        apb(1'b1, 8'h0C, 32'h0000_0200);
        chk(err, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("register map done");
    endtask : t_regs
    task automatic t_true;
        apb(1'b1, CTRL_OFF, 32'h0000_0046);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd[STAT_TRUE_OK], 1'b1);
        u_usr.op(1'b0, 1'b0, 9'h000, 1'b0, 1'b1, 1'b0, 5'd5, 16'h3D5A, 2'b11);
        u_usr.op(1'b0, 1'b0, 9'h000, 1'b0, 1'b1, 1'b0, 5'd5, 16'h00FF, 2'b01);
        u_usr.op(1'b1, 1'b0, {5'd6, 4'd3}, 1'b1, 1'b1, 1'b0, 5'd7, 16'h0000, 2'b11);
        u_usr.op(1'b0, 1'b1, {5'd5, 4'd10}, 1'b0, 1'b0, 1'b1, 5'd5, 16'h0, 2'b00);
        #1 chk({b_qpar, b_q}, {2'b10, 16'h3DFF});
        chk(a_q, 1'b1);
        u_usr.op(1'b0, 1'b1, {5'd6, 4'd3}, 1'b0, 1'b0, 1'b0, 5'd0, 16'h0, 2'b00);
        #1 chk(a_q, 1'b1);
        apb(1'b1, CTRL_OFF, 32'h0000_0066);
        u_usr.op(1'b0, 1'b0, 9'h000, 1'b0, 1'b0, 1'b1, 5'd5, 16'h0, 2'b00);
        @(posedge pclk);
        u_usr.op(1'b0, 1'b0, 9'h000, 1'b0, 1'b0, 1'b1, 5'd7, 16'h0, 2'b00);
        #1 chk(b_q, 16'h3DFF);
        @(posedge pclk);
        #1 chk(b_q, 16'h0000);
        $display("true dual-port done");
    endtask : t_true
    task automatic t_simple;
        apb(1'b1, CTRL_OFF, 32'h0000_0005);
        u_usr.op(1'b1, 1'b0, {5'd7, 4'd0}, 1'b1, 1'b0, 1'b1, 5'd7, 16'h0, 2'b00);
        #1 chk(b_q, UNDEF_PAT);
        apb(1'b1, CTRL_OFF, 32'h0000_0045);
        u_usr.op(1'b1, 1'b0, {5'd7, 4'd1}, 1'b1, 1'b0, 1'b1, 5'd7, 16'h0, 2'b00);
        #1 chk(b_q, 16'h0001);
        u_usr.op(1'b0, 1'b0, 9'h000, 1'b0, 1'b0, 1'b1, 5'd7, 16'h0, 2'b00);
        #1 chk(b_q, 16'h0003);
        $display("simple dual-port done");
    endtask : t_simple
    task automatic t_flow;
        apb(1'b1, CTRL_OFF, 32'h0000_00C1);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd[STAT_FLOW_OK], 1'b1);
        fork
            u_usr.op(1'b0, 1'b0, 9'h000, 1'b0, 1'b0, 1'b1, 5'd5, 16'h0, 2'b00);
            begin
                @(posedge pclk);
                @(negedge pclk);
                #1 chk(b_q, 16'h3DFF);
            end
        join
        apb(1'b1, CTRL_OFF, 32'h0000_0002);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd[STAT_TRUE_OK], 1'b0);
        $display("flow-through done");
    endtask : t_flow
    task automatic t_single;
        apb(1'b1, CTRL_OFF, 32'h0000_0004);
        u_usr.op(1'b1, 1'b0, {5'd8, 4'd2}, 1'b1, 1'b0, 1'b0, 5'd0, 16'h0, 2'b00);
        @(posedge pclk);
        #1 chk(a_q, 1'b1);
        $display("single-port done");
    endtask : t_single
    // two half-size single ports in a medium block must not disturb each other
    task automatic t_split;
        apb(1'b1, CTRL_OFF, 32'h0000_0104);
        u_usr.op(1'b1, 1'b0, {5'd2, 4'd0}, 1'b1, 1'b0, 1'b0, 5'd0, 16'h0, 2'b00);
        u_usr.op(1'b0, 1'b0, 9'h000, 1'b0, 1'b1, 1'b0, 5'd2, 16'h1234, 2'b11);
        u_usr.op(1'b0, 1'b1, {5'd2, 4'd0}, 1'b0, 1'b0, 1'b1, 5'd2, 16'h0, 2'b00);
        #1 chk(a_q, 1'b1);
        chk(b_q, 16'h1234);
        $display("split single-port done");
    endtask : t_split
    task automatic t_lock;
        apb(1'b1, CTRL_OFF, 32'h0000_0246);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd[STAT_LOCK], 1'b1);
        u_usr.op(1'b0, 1'b0, 9'h000, 1'b0, 1'b1, 1'b0, 5'd7, 16'hFFFF, 2'b11);
        u_usr.op(1'b0, 1'b0, 9'h000, 1'b0, 1'b0, 1'b1, 5'd7, 16'h0, 2'b00);
        #1 chk(b_q, 16'h0003);
        apb(1'b1, CTRL_OFF, 32'h0000_0046);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(rd[CTRL_LOCK], 1'b1);
        $display("lock done");
    endtask : t_lock
    // reset, then the scenarios in order; lock goes last as only reset clears it
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_true();
        t_simple();
        t_flow();
        t_single();
        t_split();
        t_lock();
        report_and_stop();
    end
endmodule : configurable_embedded_ram_bench
`default_nettype wire
